// ===== hw/dma_params.svh
// Constants shared by the multichannel DMA controller files.
//
// Functional notes
// - Source and destination sizes 8/16/32/64 independently.
// - Enabled channel runs until count equals length.
// - Terminal count sets status, interrupt when unmasked.
// - Addresses step by size unless hold set.
// - Software trigger mode paces memory transfers.
// - Null select: writes discarded, reads zero.
// - Hash feed pushes data into internal FIFO.
// - Per-channel bit picks high or low group.
// - Fixed priority, channel zero highest.
// - Granted channel masked until group serviced.
// - Low group wins only without high requests.
// - One pre-empted low burst channel resumes later.
// - Configuration bit picks core or controller bus.
// - Peripheral lines map to channels four to eleven; here each of the NCH channels has its own line.
// - Burst mode only for low group channels.
// - Request detected by level or edge.
// - Programmable endian byte swap on data.
// - Controller clears enable at terminal count.
`ifndef DMA_PARAMS_SVH
`define DMA_PARAMS_SVH
`define DMA_SIZE_8       3'h0
`define DMA_SIZE_16      3'h1
`define DMA_SIZE_32      3'h2
`define DMA_SIZE_64      3'h3
`define DMA_HTRANS_IDLE  2'h0
`define DMA_HTRANS_NSEQ  2'h2
`define DMA_HTRANS_SEQ   2'h3
`define DMA_HASH_DEPTH   4
`define DMA_NUM_CH       32
`define DMA_CH_SPI_RX    5'h04
`define DMA_CH_SPI_TX    5'h05
`define DMA_CH_AUD_FIRST 5'h06
`endif

// ===== hw/dma_pkg.sv
// Types shared by the multichannel DMA controller.
`default_nettype none
package dma_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RADDR = 3'b001,
		ST_RDATA = 3'b011,
		ST_WADDR = 3'b010,
		ST_WDATA = 3'b110,
		ST_DONE  = 3'b111
	} dma_state_t;
endpackage : dma_pkg
`default_nettype wire

// ===== hw/dma_group_arbiter.sv
// Fixed-priority fairness arbiter for one channel group.
`default_nettype none
module dma_group_arbiter #(
	parameter int N = 32
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [N-1:0] req,
	input  wire logic         take,
	output logic              any,
	output logic [N-1:0]      grant
);
	logic [N-1:0] served_q;
	logic [N-1:0] open_req;

	// Lowest index wins among requesters not yet served this round.
	always_comb begin
		open_req = req & ~served_q;
		if (open_req == '0) begin
			open_req = req;
		end
		grant = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (open_req[i]) begin
				grant = '0;
				grant[i] = 1'b1;
			end
		end
		any = |req;
	end

	// Round closes when every current requester was served once.
	always_ff @(posedge clk) begin
		if (rst) begin
			served_q <= '0;
		end else if (take) begin
			if (((served_q | grant) & req) == req) begin
				served_q <= '0;
			end else begin
				served_q <= (served_q | grant) & req;
			end
		end else begin
			served_q <= served_q & req;
		end
	end
endmodule : dma_group_arbiter
`default_nettype wire

// ===== hw/dma_hash_fifo.sv
// Two-or-more entry FIFO carrying words toward the hashing engine.
`default_nettype none
module dma_hash_fifo #(
	parameter int W     = 64,
	parameter int DEPTH = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data,
	output logic              empty
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_q != (AW + 1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign empty     = (cnt_q == '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rp_q];

	// Storage is written only on an accepted push.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	// Pointers wrap naturally; depth must be a power of two.
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end
endmodule : dma_hash_fifo
`default_nettype wire

// ===== hw/dma_controller.sv
// Multichannel DMA controller core: channel state, arbitration and AHB master.
`include "dma_params.svh"
`default_nettype none
module dma_controller #(
	parameter int NCH = `DMA_NUM_CH,
	parameter int AW  = 32,
	parameter int DW  = 64,
	parameter int CW  = 16
) (
	input  wire logic                clk,
	input  wire logic                rst,
	// Per-channel configuration, flattened by channel.
	input  wire logic [NCH-1:0]      channel_run_enable_set,
	input  wire logic [NCH*3-1:0]    src_word_size,
	input  wire logic [NCH*3-1:0]    dst_word_size,
	input  wire logic [NCH-1:0]      src_address_hold,
	input  wire logic [NCH-1:0]      dst_address_hold,
	input  wire logic [NCH-1:0]      soft_trigger_enable,
	input  wire logic [NCH-1:0]      soft_trigger,
	input  wire logic [NCH-1:0]      src_phase_handshake_sel,
	input  wire logic [NCH-1:0]      addr_phase_handshake_sel,
	input  wire logic [NCH-1:0]      zero_src_select,
	input  wire logic [NCH-1:0]      null_dst_select,
	input  wire logic [NCH-1:0]      hash_feed_enable,
	input  wire logic [NCH-1:0]      low_group_select,
	input  wire logic [NCH-1:0]      burst_enable,
	input  wire logic [NCH-1:0]      edge_detect_select,
	input  wire logic [NCH-1:0]      byte_swap_enable,
	input  wire logic [NCH-1:0]      tc_irq_mask,
	input  wire logic [NCH-1:0]      tc_status_clear,
	input  wire logic [NCH*AW-1:0]   src_base_addr,
	input  wire logic [NCH*AW-1:0]   dst_base_addr,
	input  wire logic [NCH*CW-1:0]   primary_transfer_length,
	input  wire logic                bus_owner_priority,
	// Peripheral request lines, one per channel.
	input  wire logic [NCH-1:0]      periph_req,
	output logic [NCH-1:0]           periph_ack,
	// Bus arbitration against the processor core.
	input  wire logic                core_bus_req,
	output logic                     core_bus_grant,
	// AHB master.
	output logic [AW-1:0]            haddr,
	output logic [1:0]               htrans,
	output logic                     hwrite,
	output logic [2:0]               hsize,
	output logic [DW-1:0]            hwdata,
	input  wire logic [DW-1:0]       hrdata,
	input  wire logic                hready,
	input  wire logic                hresp,
	// Hashing engine feed.
	output logic                     hash_valid,
	input  wire logic                hash_ready,
	output logic [DW-1:0]            hash_data,
	output logic                     hash_fifo_empty,
	// Status.
	output logic [NCH-1:0]           channel_run_enable,
	output logic [NCH-1:0]           tc_status,
	output logic [NCH-1:0]           preempted_status,
	output logic                     irq
);
	localparam int CIW = $clog2(NCH);

	logic [NCH-1:0]    en_q;
	logic [NCH-1:0]    tc_q;
	logic [NCH-1:0]    pend_q;
	logic [NCH-1:0]    req_prev_q;
	logic [NCH-1:0]    ack_q;
	logic [CW-1:0]     cnt_q   [NCH];
	logic [AW-1:0]     saddr_q [NCH];
	logic [AW-1:0]     daddr_q [NCH];
	logic [NCH-1:0]    preempt_q;
	dma_pkg::dma_state_t st_q;
	logic [CIW-1:0]    ch_q;
	logic [DW-1:0]     data_q;
	logic [AW-1:0]     haddr_q;
	logic [1:0]        htrans_q;
	logic              hwrite_q;
	logic [2:0]        hsize_q;
	logic [DW-1:0]     hwdata_q;
	logic [NCH-1:0]    ready_ch;
	logic [NCH-1:0]    hi_grant;
	logic [NCH-1:0]    lo_grant;
	logic              hi_any;
	logic              lo_any;
	logic [NCH-1:0]    final_grant;
	logic              take;
	logic              bus_ok;
	logic              fifo_in_ready;
	logic              fifo_push;
	logic              done_ev;
	logic [CIW-1:0]    win;

	// Byte count of a size code, used for address stepping.
	function automatic logic [AW-1:0] size_bytes(input logic [2:0] sz);
		size_bytes = AW'(1) << sz;
	endfunction : size_bytes

	// Reverse byte order within the active width of the word.
	function automatic logic [DW-1:0] swap_bytes(input logic [DW-1:0] d, input logic [2:0] sz);
		logic [DW-1:0] r;
		int            nb;
		r  = '0;
		nb = 1 << sz;
		for (int b = 0; b < DW / 8; b++) begin
			if (b < nb) begin
				r[b*8 +: 8] = d[(nb - 1 - b)*8 +: 8];
			end
		end
		swap_bytes = r;
	endfunction : swap_bytes

	////////////////////////////////////////////////////////////////////////////
	// Request detection and channel readiness.

	// Edge mode latches a rising edge so a short pulse is not missed.
	always_ff @(posedge clk) begin
		if (rst) begin
			req_prev_q <= '0;
			pend_q     <= '0;
		end else begin
			req_prev_q <= periph_req;
			for (int c = 0; c < NCH; c++) begin
				if (periph_req[c] && !req_prev_q[c]) begin
					pend_q[c] <= 1'b1;
				end else if (take && final_grant[c]) begin
					pend_q[c] <= 1'b0;
				end
			end
		end
	end

	// A channel requests when enabled and paced by trigger or handshake.
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			ready_ch[c] = en_q[c] && (soft_trigger_enable[c] ? soft_trigger[c] :
				(edge_detect_select[c] ? pend_q[c] : periph_req[c]));
		end
	end

	dma_group_arbiter #(.N(NCH)) u_hi_arb (
		.clk   (clk),
		.rst   (rst),
		.req   (ready_ch & ~low_group_select),
		.take  (take && hi_any),
		.any   (hi_any),
		.grant (hi_grant)
	);

	dma_group_arbiter #(.N(NCH)) u_lo_arb (
		.clk   (clk),
		.rst   (rst),
		.req   (ready_ch & low_group_select),
		.take  (take && !hi_any && (preempt_q == '0)),
		.any   (lo_any),
		.grant (lo_grant)
	);

	// High group first; a held pre-empted low channel resumes before new low grants.
	always_comb begin
		if (hi_any) begin
			final_grant = hi_grant;
		end else if (preempt_q != '0) begin
			final_grant = preempt_q;
		end else begin
			final_grant = lo_grant;
		end
		win = '0;
		for (int c = NCH - 1; c >= 0; c--) begin
			if (final_grant[c]) begin
				win = CIW'(c);
			end
		end
	end

	// Core contention: the priority bit decides who owns the bus.
	assign bus_ok         = bus_owner_priority || !core_bus_req;
	assign core_bus_grant = core_bus_req && (!bus_owner_priority || st_q == dma_pkg::ST_IDLE);
	assign take           = (st_q == dma_pkg::ST_IDLE) && bus_ok && (final_grant != '0);

	////////////////////////////////////////////////////////////////////////////
	// Transfer sequencer: a source read unless zero source, then a destination write unless null target.

	assign fifo_push = (st_q == dma_pkg::ST_WADDR) && hash_feed_enable[ch_q];
	assign done_ev   = (st_q == dma_pkg::ST_DONE) && (cnt_q[ch_q] + 1'b1 == primary_transfer_length[ch_q*CW +: CW]);

	// The FIFO stall holds the write phase so no hash word is lost.
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q     <= dma_pkg::ST_IDLE;
			ch_q     <= '0;
			data_q   <= '0;
			haddr_q  <= '0;
			htrans_q <= `DMA_HTRANS_IDLE;
			hwrite_q <= 1'b0;
			hsize_q  <= `DMA_SIZE_8;
			hwdata_q <= '0;
		end else begin
			case (st_q)
				dma_pkg::ST_IDLE: begin
					if (take) begin
						ch_q <= win;
						if (zero_src_select[win]) begin
							data_q <= '0;
							st_q   <= dma_pkg::ST_WADDR;
						end else begin
							haddr_q  <= saddr_q[win];
							htrans_q <= `DMA_HTRANS_NSEQ;
							hwrite_q <= 1'b0;
							hsize_q  <= src_word_size[win*3 +: 3];
							st_q     <= dma_pkg::ST_RADDR;
						end
					end
				end
				dma_pkg::ST_RADDR: begin
					if (hready) begin
						htrans_q <= `DMA_HTRANS_IDLE;
						st_q     <= dma_pkg::ST_RDATA;
					end
				end
				dma_pkg::ST_RDATA: begin
					if (hready) begin
						data_q <= byte_swap_enable[ch_q] ? swap_bytes(hrdata, src_word_size[ch_q*3 +: 3]) : hrdata;
						st_q   <= dma_pkg::ST_WADDR;
					end
				end
				dma_pkg::ST_WADDR: begin
					if (!hash_feed_enable[ch_q] || fifo_in_ready) begin
						if (null_dst_select[ch_q]) begin
							st_q <= dma_pkg::ST_DONE;
						end else begin
							haddr_q  <= daddr_q[ch_q];
							htrans_q <= `DMA_HTRANS_NSEQ;
							hwrite_q <= 1'b1;
							hsize_q  <= dst_word_size[ch_q*3 +: 3];
							hwdata_q <= data_q;
							st_q     <= dma_pkg::ST_WDATA;
						end
					end
				end
				dma_pkg::ST_WDATA: begin
					if (hready && htrans_q != `DMA_HTRANS_IDLE) begin
						htrans_q <= `DMA_HTRANS_IDLE;
						hwrite_q <= 1'b0;
					end else if (hready) begin
						st_q <= dma_pkg::ST_DONE;
					end
				end
				dma_pkg::ST_DONE: begin
					st_q <= dma_pkg::ST_IDLE;
				end
				default: begin
					st_q <= dma_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// A low burst channel that sees a high request as a non-final word completes is held pre-empted.
	always_ff @(posedge clk) begin
		if (rst) begin
			preempt_q <= '0;
		end else if (take && final_grant == preempt_q) begin
			preempt_q <= '0;
		end else if (st_q == dma_pkg::ST_DONE && hi_any && low_group_select[ch_q] && burst_enable[ch_q] &&
			!done_ev && preempt_q == '0) begin
			preempt_q <= NCH'(1) << ch_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel counters, addresses, enables and terminal count.

	// Enable stays set until terminal count; status set wins over its clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			en_q  <= '0;
			tc_q  <= '0;
			ack_q <= '0;
			for (int c = 0; c < NCH; c++) begin
				cnt_q[c]   <= '0;
				saddr_q[c] <= '0;
				daddr_q[c] <= '0;
			end
		end else begin
			ack_q <= '0;
			for (int c = 0; c < NCH; c++) begin
				if (channel_run_enable_set[c] && !en_q[c]) begin
					en_q[c]    <= 1'b1;
					cnt_q[c]   <= '0;
					saddr_q[c] <= src_base_addr[c*AW +: AW];
					daddr_q[c] <= dst_base_addr[c*AW +: AW];
				end
				if (tc_status_clear[c]) begin
					tc_q[c] <= 1'b0;
				end
			end
			if (st_q == dma_pkg::ST_DONE) begin
				ack_q[ch_q] <= !soft_trigger_enable[ch_q];
				cnt_q[ch_q] <= cnt_q[ch_q] + 1'b1;
				if (!src_address_hold[ch_q]) begin
					saddr_q[ch_q] <= saddr_q[ch_q] + size_bytes(src_word_size[ch_q*3 +: 3]);
				end
				if (!dst_address_hold[ch_q]) begin
					daddr_q[ch_q] <= daddr_q[ch_q] + size_bytes(dst_word_size[ch_q*3 +: 3]);
				end
				if (done_ev) begin
					en_q[ch_q] <= 1'b0;
					tc_q[ch_q] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Hash feed and outputs.

	dma_hash_fifo #(.W(DW), .DEPTH(`DMA_HASH_DEPTH)) u_hash_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (data_q),
		.out_valid (hash_valid),
		.out_ready (hash_ready),
		.out_data  (hash_data),
		.empty     (hash_fifo_empty)
	);

	assign haddr              = haddr_q;
	assign htrans             = htrans_q;
	assign hwrite             = hwrite_q;
	assign hsize              = hsize_q;
	assign hwdata             = hwdata_q;
	assign periph_ack         = ack_q;
	assign channel_run_enable = en_q;
	assign tc_status          = tc_q;
	assign preempted_status   = preempt_q;
	assign irq                = |(tc_q & tc_irq_mask);
endmodule : dma_controller
`default_nettype wire

// ===== bench/dma_controller_assertions.sv
// Port-level assertions for the DMA controller.
`default_nettype none
module dma_controller_assertions #(
	parameter int NCH = 32,
	parameter int AW  = 32,
	parameter int DW  = 64
) (
	input wire logic           clk,
	input wire logic           rst,
	input wire logic [NCH-1:0] channel_run_enable_set,
	input wire logic [NCH-1:0] tc_irq_mask,
	input wire logic [NCH-1:0] tc_status_clear,
	input wire logic           bus_owner_priority,
	input wire logic           core_bus_req,
	input wire logic           core_bus_grant,
	input wire logic [NCH-1:0] periph_ack,
	input wire logic [AW-1:0]  haddr,
	input wire logic [1:0]     htrans,
	input wire logic           hwrite,
	input wire logic [2:0]     hsize,
	input wire logic           hready,
	input wire logic           hash_valid,
	input wire logic           hash_ready,
	input wire logic [DW-1:0]  hash_data,
	input wire logic           hash_fifo_empty,
	input wire logic [NCH-1:0] channel_run_enable,
	input wire logic [NCH-1:0] tc_status,
	input wire logic           irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [NCH-1:0] start_q;
	logic [NCH-1:0] keep_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	// Channels told to start, and status bits that nothing is clearing.
	always_ff @(posedge clk) begin
		start_q <= rst ? '0 : channel_run_enable_set & ~channel_run_enable;
		keep_q  <= rst ? '0 : tc_status & ~tc_status_clear;
	end
	////////////////////////////////////////////////////////////////////////
	a_irq_is_or: assert property (irq == |(tc_status & tc_irq_mask))
		else $error("irq differs from masked status");
	a_tc_drops_run: assert property ((tc_status & ~$past(tc_status) & channel_run_enable) == '0)
		else $error("channel still running at terminal count");
	a_tc_needs_run: assert property ((tc_status & ~$past(tc_status) & ~$past(channel_run_enable)) == '0)
		else $error("terminal count on idle channel");
	a_tc_sticky: assert property ((keep_q & ~tc_status) == '0)
		else $error("status lost without clear");
	a_start_runs: assert property (|start_q |-> (channel_run_enable & start_q) == start_q)
		else $error("enabled channel not running");
	// With the core given priority, its request is granted at once, even in mid-transfer.
	a_core_wins: assert property (!bus_owner_priority && core_bus_req |-> core_bus_grant)
		else $error("core not granted");
	a_dma_wins: assert property (bus_owner_priority && htrans == 2'h2 |-> !core_bus_grant)
		else $error("core granted during transfer");
	a_nseq_waits: assert property (htrans == 2'h2 && !hready |=>
		htrans == 2'h2 && $stable(haddr) && $stable(hwrite)) else $error("request dropped before ready");
	a_size_legal: assert property (htrans == 2'h2 |-> hsize <= 3'h3)
		else $error("illegal transfer size");
	a_ack_pulse: assert property (periph_ack != '0 |-> $onehot(periph_ack) ##1 periph_ack == '0)
		else $error("acknowledge not a single pulse");
	a_hash_valid: assert property (hash_valid && !hash_ready |=> hash_valid && $stable(hash_data))
		else $error("feed word changed while stalled");
endmodule : dma_controller_assertions
`default_nettype wire

// ===== bench/ahb_mem_model.sv
// Memory slave on the DMA bus; read data is derived from the address.
`default_nettype none
module ahb_mem_model (
	input wire logic         clk,
	input wire logic         rst,
	input wire logic         slow,
	input wire logic [31:0]  haddr,
	input wire logic [1:0]   htrans,
	input wire logic         hwrite,
	output logic             hready,
	output logic [63:0]      hrdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        rd_q;
	logic [31:0] a_q;
	logic [31:0] junk_q;
	////////////////////////////////////////////////////////////////////////
	// Slow mode inserts a wait state every other cycle; junk changes so stale data never matches.
	always_ff @(posedge clk) begin
		junk_q <= rst ? 32'h0 : junk_q + 32'h1357_9BDF;
		if (rst) begin
			rd_q   <= 1'b0;
			hready <= 1'b1;
		end else begin
			hready <= !slow || !hready;
			if (hready) begin
				rd_q <= htrans == 2'h2 && !hwrite;
				a_q  <= haddr;
			end
		end
	end
	assign hrdata = rd_q ? {~a_q, a_q} : {junk_q, ~junk_q};
endmodule : ahb_mem_model
`default_nettype wire

// ===== bench/multichannel_dma_controller_test.sv
// Self-checking bench for the multichannel DMA controller.
`include "dma_params.svh"
`default_nettype none
module multichannel_dma_controller_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [1:0] c;
		logic [2:0] s, d;
		logic       hs, hd, w, z, n, sft;
		logic [7:0] l;
	} row_t;
	// Channel, sizes, holds, swap, zero source, null target, soft pacing, length.
	localparam row_t ROWS [4] = '{
		'{2'h0, 3'h3, 3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 8'h03},
		'{2'h1, 3'h0, 3'h2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h02},
		'{2'h2, 3'h2, 3'h2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h02},
		'{2'h3, 3'h2, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h02}};
	localparam logic [1:0] ORDER [6] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2};
	localparam logic [127:0] SB = {32'h0000_3000, 32'h0000_2000, 32'h0000_1000, 32'h0};
	logic        clk, rst, bop, creq, slow, hrdy_h, hready, hwrite, cgnt, hv, hfe, irq, wd_q;
	logic [3:0]  go, hs, hd, se, st, psel, asel, zs, nd, hf, lo, ed, sw, msk, clr, preq, ack, en, tc, bst, pre;
	logic [11:0] ss, ds;
	logic [31:0] len, haddr, sa, da;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [63:0] hwdata, hrdata, hdat;
	logic [34:0] rq[$], wq[$];
	logic [63:0] dq[$];
	int          bad_count, checks_done, nh, nack;
	row_t        r;
	////////////////////////////////////////////////////////////////////////
	dma_controller #(.NCH(4), .CW(8)) u_dut (.clk, .rst, .channel_run_enable_set(go),
		.src_word_size(ss), .dst_word_size(ds), .src_address_hold(hs), .dst_address_hold(hd),
		.soft_trigger_enable(se), .soft_trigger(st), .src_phase_handshake_sel(psel),
		.addr_phase_handshake_sel(asel), .zero_src_select(zs), .null_dst_select(nd),
		.hash_feed_enable(hf), .low_group_select(lo), .burst_enable(bst), .edge_detect_select(ed),
		.byte_swap_enable(sw), .tc_irq_mask(msk), .tc_status_clear(clr), .src_base_addr(SB),
		.dst_base_addr(SB | {4{32'h0000_8000}}), .primary_transfer_length(len),
		.bus_owner_priority(bop), .periph_req(preq), .periph_ack(ack), .core_bus_req(creq),
		.core_bus_grant(cgnt), .haddr, .htrans, .hwrite, .hsize, .hwdata, .hrdata, .hready,
		.hresp(1'b0), .hash_valid(hv), .hash_ready(hrdy_h), .hash_data(hdat),
		.hash_fifo_empty(hfe), .channel_run_enable(en), .tc_status(tc), .preempted_status(pre), .irq);
	ahb_mem_model u_mem (.clk, .rst, .slow, .haddr, .htrans, .hwrite, .hready, .hrdata);
	////////////////////////////////////////////////////////////////////////
	// Clock and bus monitor; the monitor sees values from before each edge.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (hready && wd_q) dq.push_back(hwdata);
		if (hready) wd_q <= htrans == 2'h2 && hwrite;
		if (hready && htrans == 2'h2 && hwrite) wq.push_back({hsize, haddr});
		if (hready && htrans == 2'h2 && !hwrite) rq.push_back({hsize, haddr});
		if (hv && hrdy_h) nh++;
		if (|ack) nack++;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(logic [63:0] got, logic [63:0] exp, string m);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// Every test starts from a quiet configuration with all interrupts unmasked.
	task automatic clean();
		{go, hs, hd, se, st, psel, asel, zs, nd, hf, lo, ed, sw, clr, preq, bst} = '0;
		{ss, ds, len} = '0;
		msk = 4'hF;
		rq.delete();
		wq.delete();
		dq.delete();
		nh = 0;
		nack = 0;
	endtask : clean
	task automatic start(logic [3:0] m);
		go = m;
		cyc(1);
		go = 4'h0;
		cyc(1);
	endtask : start
	task automatic until_idle(logic [3:0] m);
		int k;
		k = 0;
		while ((en & m) !== 4'h0 && k < 600) begin
			cyc(1);
			k++;
		end
		chk(k < 600, 1, "channel stuck");
	endtask : until_idle
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////
	// A hang past the longest expected run is a failure.
	initial begin
		repeat (6000) @(posedge clk);
		bad_count++;
		summarize();
	end
	// Main sequence: table rows first, then hand-written cases.
	initial begin
		clean();
		{bad_count, checks_done, wd_q, slow} = '0;
		{rst, bop, creq, hrdy_h} = 4'hF;
		cyc(20);
		rst = 1'b0;
		foreach (ROWS[i]) begin
			r = ROWS[i];
			clean();
			ss[r.c*3+:3] = r.s;
			ds[r.c*3+:3] = r.d;
			{hs[r.c], hd[r.c], sw[r.c], zs[r.c], nd[r.c]} = {r.hs, r.hd, r.w, r.z, r.n};
			{se[r.c], st[r.c], preq[r.c]} = {r.sft, r.sft, !r.sft};
			psel[r.c] = !r.sft;
			msk[r.c] = i != 3;
			len[r.c*8+:8] = r.l;
			start(4'h1 << r.c);
			until_idle(4'hF);
			cyc(1); // The last acknowledge rises with the enable's fall and is counted at the next edge.
			{preq, st} = '0;
			for (int j = 0; j < r.l; j++) begin
				sa = (32'(r.c) << 12) + (r.hs ? 32'h0 : 32'(j) << r.s);
				da = 32'h0000_8000 + (32'(r.c) << 12) + (r.hd ? 32'h0 : 32'(j) << r.d);
				if (!r.z) chk(rq[j], {r.s, sa}, "read address and size");
				if (!r.n) chk(wq[j], {r.d, da}, "write address and size");
				if (r.z) chk(dq[j], 64'h0, "zero source data");
				if (r.w) chk(dq[j], 64'({<<8{~sa, sa}}), "swapped data");
			end
			chk(rq.size(), r.z ? 0 : r.l, "read count");
			chk(wq.size(), r.n ? 0 : r.l, "write count");
			chk(nack, r.sft ? 0 : r.l, "acknowledges");
			chk({en[r.c], tc[r.c], irq}, {2'b01, i != 3}, "end state");
			clr[r.c] = 1'b1;
			cyc(1);
			chk({tc[r.c], irq}, 2'b00, "status cleared");
		end
		// Two high channels and one low: fairness within high, low waits.
		clean();
		{se, st, lo, len, slow} = {4'h7, 4'h7, 4'h4, 32'h0002_0202, 1'b1};
		start(4'h7);
		until_idle(4'hF);
		foreach (ORDER[k]) chk(rq[k][13:12], ORDER[k], "grant order");
		// The core owns the bus until it lets go.
		clean();
		{bop, slow, se[3], st[3], len[31:24]} = {3'b001, 1'b1, 8'h01};
		start(4'h8);
		cyc(20);
		chk({rq.size(), cgnt}, {32'h0, 1'b1}, "core holds bus");
		creq = 1'b0;
		until_idle(4'h8);
		chk(rq.size(), 1, "transfer after core");
		{bop, creq} = 2'b11;
		// Edge pacing: a held request moves one word only.
		clean();
		{ed[2], len[23:16]} = {1'b1, 8'h03};
		start(4'h4);
		for (int k = 1; k <= 3; k++) begin
			preq[2] = 1'b1;
			cyc(40);
			chk(rq.size(), k, "one word per edge");
			preq[2] = 1'b0;
			cyc(2);
		end
		chk(en[2], 1'b0, "edge channel done");
		// Feed buffer fills while the hashing side stalls, then drains.
		clean();
		{hrdy_h, hf[1], se[1], st[1], len[15:8]} = {4'h7, 8'h06};
		start(4'h2);
		cyc(100);
		chk({wq.size(), en[1]}, {32'(`DMA_HASH_DEPTH), 1'b1}, "feed full stalls");
		chk(hdat, {~32'h0000_1000, 32'h0000_1000}, "feed head word");
		hrdy_h = 1'b1;
		until_idle(4'h2);
		cyc(10);
		chk({nh, hfe}, {32'h6, 1'b1}, "feed drained");
		// A low burst channel yields one word to a high channel and then resumes.
		clean();
		{se, st, lo, bst, len, slow} = {4'h5, 4'h5, 4'h4, 4'h4, 32'h0004_0001, 1'b0};
		start(4'h4);
		start(4'h1);
		cyc(6);
		chk({pre, en[0]}, 5'h09, "low burst held");
		until_idle(4'h5);
		chk({rq.size(), rq[1][13:12], pre}, {32'h5, 2'h0, 4'h0}, "low burst resumed");
		// Reset in mid-transfer stops everything and the channel stays off.
		clean();
		{se[0], st[0], len[7:0]} = {2'b11, 8'h08};
		start(4'h1);
		cyc(10);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		chk({en, tc, htrans}, 64'h0, "reset clears");
		cyc(20);
		chk(en, 4'h0, "no restart without enable");
		summarize();
	end
endmodule : multichannel_dma_controller_test
bind dma_controller dma_controller_assertions #(.NCH(NCH), .AW(AW), .DW(DW)) u_chk (.clk, .rst,
	.channel_run_enable_set, .tc_irq_mask, .tc_status_clear, .bus_owner_priority, .core_bus_req,
	.core_bus_grant, .periph_ack, .haddr, .htrans, .hwrite, .hsize, .hready, .hash_valid,
	.hash_ready, .hash_data,
	.hash_fifo_empty, .channel_run_enable, .tc_status, .irq);
`default_nettype wire
